// File: hw/pmcs_averager.sv
// Per-quantity averaging accumulator
`timescale 1ns/1ps

module pmcs_averager
(
  // Clock and reset
  input  wire logic               clock_in,
  input  wire logic               reset_in,
  // Control
  input  wire logic               clear_in,
  input  wire logic               add_in,
  input  wire logic        [3:0]  shift_in,
  // Data
  input  wire logic signed [15:0] sample_in,
  output logic signed      [15:0] mean_out
);

  logic signed [25:0] sum;
  logic signed [25:0] shifted;

  assign shifted  = sum >>> shift_in;
  assign mean_out = shifted[15:0];

  // Clear wins so a restart never carries stale samples
  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
      sum <= 26'sh0;
    else if (clear_in)
      sum <= 26'sh0;
    else if (add_in)
      sum <= sum + 26'(sample_in);
  end

endmodule

// File: hw/pmcs_pkg.sv
// Constants shared by the power monitor conversion sequencer
package pmcs_pkg;

  // ****************************************************************
  // Register addresses (word index on the plain register port)
  // ****************************************************************
  localparam logic [3:0] ADDR_CONFIG     = 4'h0;
  localparam logic [3:0] ADDR_ADC_CONFIG = 4'h1;
  localparam logic [3:0] ADDR_BUS_V      = 4'h2;
  localparam logic [3:0] ADDR_TEMP       = 4'h3;
  localparam logic [3:0] ADDR_CURRENT    = 4'h4;
  localparam logic [3:0] ADDR_POWER      = 4'h5;
  localparam logic [3:0] ADDR_ENERGY_HI  = 4'h6;
  localparam logic [3:0] ADDR_ENERGY_LO  = 4'h7;
  localparam logic [3:0] ADDR_CHARGE_HI  = 4'h8;
  localparam logic [3:0] ADDR_CHARGE_LO  = 4'h9;
  localparam logic [3:0] ADDR_DIAG       = 4'hA;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CFG_DELAY_LSB  = 6;
  localparam int ADC_MODE_LSB   = 12;
  localparam int ADC_CT_BUS_LSB = 9;
  localparam int ADC_CT_SH_LSB  = 6;
  localparam int ADC_CT_T_LSB   = 3;
  localparam int ADC_AVG_LSB    = 0;
  localparam int DIAG_ALERT_EN  = 0;
  localparam int DIAG_READY     = 1;
  localparam int DIAG_ACC_VALID = 2;
  localparam int MODE_BUS_BIT   = 0;
  localparam int MODE_CUR_BIT   = 1;
  localparam int MODE_CONT_BIT  = 2;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_DELAY  = 8'h00;
  localparam logic [2:0] RST_MODE   = 3'h7;
  localparam logic [2:0] RST_CT     = 3'h5;
  localparam logic [2:0] RST_AVG    = 3'h0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ          = 20_000_000;
  localparam int TICK_US         = 1;
  localparam int TICK_CYCLES     = CLK_HZ / 1_000_000 * TICK_US;
  localparam int DELAY_STEP_MS   = 2;
  localparam int DELAY_STEP_US   = DELAY_STEP_MS * 1000;
  localparam int DELAY_MAX_MS    = 510;
  localparam int CT_MIN_US       = 50;
  localparam int CT_MAX_US       = 4120;
  localparam logic [12:0] CT_US [8] = '{13'h0032, 13'h0054, 13'h0096, 13'h0118,
                                        13'h021C, 13'h041C, 13'h081A, 13'h1018};
  localparam logic [3:0]  AVG_SHIFT [8] = '{4'h0, 4'h2, 4'h4, 4'h6,
                                            4'h7, 4'h8, 4'h9, 4'hA};

  // ****************************************************************
  // Input selector codes and arithmetic
  // ****************************************************************
  localparam logic [1:0] SEL_SHUNT = 2'h0;
  localparam logic [1:0] SEL_BUS   = 2'h1;
  localparam logic [1:0] SEL_TEMP  = 2'h2;
  localparam int TC_SHIFT          = 6;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_DELAY  = 3'b001,
    ST_TEMP   = 3'b011,
    ST_SHUNT  = 3'b010,
    ST_BUS    = 3'b110,
    ST_FINISH = 3'b111
  } pmcs_state_e;

endpackage

// File: hw/pmcs_sequencer.sv
// Conversion sequencer and calculation engine of the power monitor
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ps

module pmcs_sequencer
#(
  parameter int TICK_DIV = pmcs_pkg::TICK_CYCLES
)
(
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        reset_in,
  // Register port
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        reg_write_in,
  input  wire logic        reg_read_in,
  output logic      [15:0] reg_rdata_out,
  // Converter
  input  wire logic [15:0] adc_data_in,
  output logic      [1:0]  input_select_out,
  output logic             converter_on_out,
  output logic             filter_restart_out,
  // Status
  output logic             ready_alert_out,
  output logic             shutdown_out
);

  // ****************************************************************
  // Timebase
  // ****************************************************************
  logic [15:0] div_cnt;
  logic        tick;

  assign tick = (div_cnt == 16'(TICK_DIV - 1));

  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
      div_cnt <= 16'h0000;
    else if (tick)
      div_cnt <= 16'h0000;
    else
      div_cnt <= div_cnt + 16'h0001;
  end

  // ****************************************************************
  // Register decode
  // ****************************************************************
  logic [7:0] start_delay_field;
  logic [2:0] mode;
  logic [2:0] ct_bus;
  logic [2:0] ct_shunt;
  logic [2:0] ct_temp;
  logic [2:0] avg_code;
  logic       ready_alert_enable;
  logic       conversion_ready_flag;
  logic       acc_valid;

  wire wr_cfg   = reg_write_in && (reg_addr_in == pmcs_pkg::ADDR_CONFIG);
  wire wr_adc   = reg_write_in && (reg_addr_in == pmcs_pkg::ADDR_ADC_CONFIG);
  wire wr_diag  = reg_write_in && (reg_addr_in == pmcs_pkg::ADDR_DIAG);
  wire rd_diag  = reg_read_in && (reg_addr_in == pmcs_pkg::ADDR_DIAG);
  wire [2:0] new_mode = reg_wdata_in[pmcs_pkg::ADC_MODE_LSB +: 3];
  wire new_run  = new_mode[pmcs_pkg::MODE_BUS_BIT] | new_mode[pmcs_pkg::MODE_CUR_BIT];
  wire cur_en   = mode[pmcs_pkg::MODE_CUR_BIT];
  wire bus_en   = mode[pmcs_pkg::MODE_BUS_BIT];
  wire cont     = mode[pmcs_pkg::MODE_CONT_BIT];

  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      start_delay_field  <= pmcs_pkg::RST_DELAY;
      mode               <= pmcs_pkg::RST_MODE;
      ct_bus             <= pmcs_pkg::RST_CT;
      ct_shunt           <= pmcs_pkg::RST_CT;
      ct_temp            <= pmcs_pkg::RST_CT;
      avg_code           <= pmcs_pkg::RST_AVG;
      ready_alert_enable <= 1'b0;
    end
    else
    begin
      if (wr_cfg)
        start_delay_field <= reg_wdata_in[pmcs_pkg::CFG_DELAY_LSB +: 8];
      if (wr_adc)
      begin
        mode     <= new_mode;
        ct_bus   <= reg_wdata_in[pmcs_pkg::ADC_CT_BUS_LSB +: 3];
        ct_shunt <= reg_wdata_in[pmcs_pkg::ADC_CT_SH_LSB +: 3];
        ct_temp  <= reg_wdata_in[pmcs_pkg::ADC_CT_T_LSB +: 3];
        avg_code <= reg_wdata_in[pmcs_pkg::ADC_AVG_LSB +: 3];
      end
      if (wr_diag)
        ready_alert_enable <= reg_wdata_in[pmcs_pkg::DIAG_ALERT_EN];
    end
  end

  // ****************************************************************
  // Sequence state machine
  // ****************************************************************
  pmcs_pkg::pmcs_state_e state;
  pmcs_pkg::pmcs_state_e next_state;
  logic [18:0] timer;
  logic [18:0] target;
  logic [10:0] sample_cnt;
  logic        delay_pending;

  wire [18:0] delay_us   = 19'(start_delay_field) * 19'(pmcs_pkg::DELAY_STEP_US);
  wire [10:0] avg_n      = 11'h001 << pmcs_pkg::AVG_SHIFT[avg_code];
  wire        last_pass  = (sample_cnt + 11'h001) == avg_n;
  wire        period_end = tick && (timer == target - 19'h00001);
  wire        converting = (state == pmcs_pkg::ST_TEMP) || (state == pmcs_pkg::ST_SHUNT)
                           || (state == pmcs_pkg::ST_BUS);
  wire        publish    = (state == pmcs_pkg::ST_FINISH) && last_pass;
  wire pmcs_pkg::pmcs_state_e first_ch = cur_en ? pmcs_pkg::ST_TEMP : pmcs_pkg::ST_BUS;

  // Each input keeps its own programmed period
  always_comb
  begin
    unique case (state)
      pmcs_pkg::ST_TEMP:  target = 19'(pmcs_pkg::CT_US[ct_temp]);
      pmcs_pkg::ST_SHUNT: target = 19'(pmcs_pkg::CT_US[ct_shunt]);
      pmcs_pkg::ST_BUS:   target = 19'(pmcs_pkg::CT_US[ct_bus]);
      pmcs_pkg::ST_DELAY: target = delay_us;
      default:            target = 19'h00001;
    endcase
  end

  always_comb
  begin
    next_state = state;
    unique case (state)
      pmcs_pkg::ST_IDLE:   next_state = pmcs_pkg::ST_IDLE;
      pmcs_pkg::ST_DELAY:  if (period_end) next_state = first_ch;
      pmcs_pkg::ST_TEMP:   if (period_end) next_state = pmcs_pkg::ST_SHUNT;
      pmcs_pkg::ST_SHUNT:
        if (period_end)
          next_state = bus_en ? pmcs_pkg::ST_BUS : pmcs_pkg::ST_FINISH;
      pmcs_pkg::ST_BUS:    if (period_end) next_state = pmcs_pkg::ST_FINISH;
      pmcs_pkg::ST_FINISH:
        if (last_pass && !cont)
          next_state = pmcs_pkg::ST_IDLE;
        else
          next_state = first_ch;
      default:             next_state = pmcs_pkg::ST_IDLE;
    endcase
    if (wr_adc)
    begin
      if (!new_run)
        next_state = pmcs_pkg::ST_IDLE;
      else if (start_delay_field != 8'h00)
        next_state = pmcs_pkg::ST_DELAY;
      else
        next_state = new_mode[pmcs_pkg::MODE_CUR_BIT] ? pmcs_pkg::ST_TEMP
                                                      : pmcs_pkg::ST_BUS;
    end
  end

  // Reads are never decoded here, so polling cannot stall a sequence
  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state      <= pmcs_pkg::ST_IDLE;
      timer      <= 19'h00000;
      sample_cnt <= 11'h000;
    end
    else
    begin
      state <= next_state;
      if (next_state != state || wr_adc)
        timer <= 19'h00000;
      else if (tick)
        timer <= timer + 19'h00001;
      if (wr_adc || publish)
        sample_cnt <= 11'h000;
      else if (state == pmcs_pkg::ST_FINISH)
        sample_cnt <= sample_cnt + 11'h001;
    end
  end

  // ****************************************************************
  // Sample capture and background arithmetic
  // ****************************************************************
  logic signed [15:0] temp_sample;
  logic signed [15:0] current_now;
  logic signed [31:0] charge;
  logic signed [31:0] energy;
  logic signed [15:0] mean_current;
  logic signed [15:0] mean_bus;
  logic signed [15:0] mean_temp;

  wire end_temp  = period_end && (state == pmcs_pkg::ST_TEMP);
  wire end_shunt = period_end && (state == pmcs_pkg::ST_SHUNT);
  wire end_bus   = period_end && (state == pmcs_pkg::ST_BUS);
  wire signed [15:0] adc_s     = $signed(adc_data_in);
  wire signed [15:0] corrected = adc_s - (temp_sample >>> pmcs_pkg::TC_SHIFT);
  wire signed [31:0] power_now = current_now * adc_s;
  wire signed [31:0] power_avg = mean_current * mean_bus;
  wire avg_clear = wr_adc || publish;
  wire [3:0] avg_shift = pmcs_pkg::AVG_SHIFT[avg_code];

  // Single-cycle arithmetic alongside the timer, so periods stay exact
  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      temp_sample <= 16'sh0000;
      current_now <= 16'sh0000;
      charge      <= 32'sh00000000;
      energy      <= 32'sh00000000;
      acc_valid   <= 1'b0;
    end
    else
    begin
      if (end_temp)
        temp_sample <= adc_s;
      if (end_shunt)
        current_now <= corrected;
      if (wr_adc)
        acc_valid <= new_mode[pmcs_pkg::MODE_CONT_BIT] && new_run;
      if (wr_adc && !(new_mode[pmcs_pkg::MODE_CONT_BIT] && acc_valid))
      begin
        charge <= 32'sh00000000;
        energy <= 32'sh00000000;
      end
      else if (acc_valid)
      begin
        if (end_shunt)
          charge <= charge + 32'(corrected);
        if (end_bus)
          energy <= energy + power_now;
      end
    end
  end

  pmcs_averager u_avg_current
  (
    .clock_in  (clock_in),
    .reset_in  (reset_in),
    .clear_in  (avg_clear),
    .add_in    (end_shunt),
    .shift_in  (avg_shift),
    .sample_in (corrected),
    .mean_out  (mean_current)
  );

  pmcs_averager u_avg_bus
  (
    .clock_in  (clock_in),
    .reset_in  (reset_in),
    .clear_in  (avg_clear),
    .add_in    (end_bus),
    .shift_in  (avg_shift),
    .sample_in (adc_s),
    .mean_out  (mean_bus)
  );

  pmcs_averager u_avg_temp
  (
    .clock_in  (clock_in),
    .reset_in  (reset_in),
    .clear_in  (avg_clear),
    .add_in    (end_temp),
    .shift_in  (avg_shift),
    .sample_in (adc_s),
    .mean_out  (mean_temp)
  );

  // ****************************************************************
  // Published results and ready flag
  // ****************************************************************
  logic [15:0] res_current;
  logic [15:0] res_bus;
  logic [15:0] res_temp;
  logic [15:0] res_power;

  wire ready_clear = (wr_adc && new_run) || rd_diag;

  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      res_current           <= 16'h0000;
      res_bus               <= 16'h0000;
      res_temp              <= 16'h0000;
      res_power             <= 16'h0000;
      conversion_ready_flag <= 1'b0;
    end
    else
    begin
      // Only the last pass of an average replaces results; channels not run keep theirs
      if (publish)
      begin
        if (cur_en)
        begin
          res_current <= mean_current;
          res_temp    <= mean_temp;
        end
        if (bus_en)
          res_bus <= mean_bus;
        if (cur_en && bus_en)
          res_power <= power_avg[31:16];
      end
      // Completion set beats a same-cycle clear
      if (publish)
        conversion_ready_flag <= 1'b1;
      else if (ready_clear)
        conversion_ready_flag <= 1'b0;
    end
  end

  // ****************************************************************
  // Read data and outputs
  // ****************************************************************
  logic [15:0] rd_mux;
  wire  [15:0] adc_cfg_word = {1'b0, mode, ct_bus, ct_shunt, ct_temp, avg_code};
  wire  [15:0] diag_word    = {13'h0000, acc_valid, conversion_ready_flag, ready_alert_enable};

  always_comb
  begin
    unique case (reg_addr_in)
      pmcs_pkg::ADDR_CONFIG:     rd_mux = {2'b00, start_delay_field, 6'h00};
      pmcs_pkg::ADDR_ADC_CONFIG: rd_mux = adc_cfg_word;
      pmcs_pkg::ADDR_BUS_V:      rd_mux = res_bus;
      pmcs_pkg::ADDR_TEMP:       rd_mux = res_temp;
      pmcs_pkg::ADDR_CURRENT:    rd_mux = res_current;
      pmcs_pkg::ADDR_POWER:      rd_mux = res_power;
      pmcs_pkg::ADDR_ENERGY_HI:  rd_mux = energy[31:16];
      pmcs_pkg::ADDR_ENERGY_LO:  rd_mux = energy[15:0];
      pmcs_pkg::ADDR_CHARGE_HI:  rd_mux = charge[31:16];
      pmcs_pkg::ADDR_CHARGE_LO:  rd_mux = charge[15:0];
      pmcs_pkg::ADDR_DIAG:       rd_mux = diag_word;
      default:                   rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      reg_rdata_out      <= 16'h0000;
      input_select_out   <= pmcs_pkg::SEL_SHUNT;
      converter_on_out   <= 1'b0;
      filter_restart_out <= 1'b0;
      ready_alert_out    <= 1'b0;
      shutdown_out       <= 1'b1;
    end
    else
    begin
      reg_rdata_out <= reg_read_in ? rd_mux : 16'h0000;
      unique case (next_state)
        pmcs_pkg::ST_TEMP:  input_select_out <= pmcs_pkg::SEL_TEMP;
        pmcs_pkg::ST_BUS:   input_select_out <= pmcs_pkg::SEL_BUS;
        default:            input_select_out <= pmcs_pkg::SEL_SHUNT;
      endcase
      converter_on_out   <= (next_state == pmcs_pkg::ST_TEMP)
                            || (next_state == pmcs_pkg::ST_SHUNT)
                            || (next_state == pmcs_pkg::ST_BUS);
      // Filter restarts with each period so it settles inside it
      // A mode write that aborts a period restarts the filter too
      filter_restart_out <= converting ? (period_end || wr_adc) : (next_state != state);
      ready_alert_out    <= ready_alert_enable
                            && (conversion_ready_flag || publish) && !ready_clear;
      shutdown_out       <= (next_state == pmcs_pkg::ST_IDLE);
    end
  end

endmodule

// File: testbench/pmcs_adc_model.sv
// Behavioural converter answering the sequencer's input selector
`timescale 1ns/1ps

module pmcs_adc_model
(
  // Clock
  input  wire logic        clock_in,
  // Selector side
  input  wire logic [1:0]  select_in,
  input  wire logic        convert_in,
  // Levels set by the bench
  input  wire logic [15:0] shunt_level_in,
  input  wire logic [15:0] bus_level_in,
  input  wire logic [15:0] temp_level_in,
  // Result
  output logic      [15:0] result_out
);
  // Idle result flips each cycle so a stray sample never looks real
  logic [15:0] junk = 16'h5A5A;
  wire  [15:0] picked = (select_in == pmcs_pkg::SEL_SHUNT) ? shunt_level_in :
                        (select_in == pmcs_pkg::SEL_BUS)   ? bus_level_in :
                        (select_in == pmcs_pkg::SEL_TEMP)  ? temp_level_in : junk;

  // Plain always: the declaration seeds the pattern, so no reset is needed
  always @(posedge clock_in)
    junk <= ~junk;

  assign result_out = convert_in ? picked : junk;
endmodule

// File: testbench/pmcs_sequencer_asserts.sv
// Port assertions for the power monitor conversion sequencer
`timescale 1ns/1ps

module pmcs_sequencer_asserts
(
  // Clock and reset
  input wire logic        clock_in,
  input wire logic        reset_in,
  // Register port
  input wire logic [3:0]  reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic        reg_write_in,
  input wire logic        reg_read_in,
  input wire logic [15:0] reg_rdata_out,
  // Converter and status
  input wire logic [15:0] adc_data_in,
  input wire logic [1:0]  input_select_out,
  input wire logic        converter_on_out,
  input wire logic        filter_restart_out,
  input wire logic        ready_alert_out,
  input wire logic        shutdown_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (reset_in);

  wire cfg_wr  = reg_write_in && reg_addr_in == pmcs_pkg::ADDR_ADC_CONFIG;
  wire run_wr  = cfg_wr && reg_wdata_in[13:12] != 2'h0;
  wire stop_wr = cfg_wr && reg_wdata_in[13:12] == 2'h0;
  wire diag_rd = reg_read_in && reg_addr_in == pmcs_pkg::ADDR_DIAG;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_rdata_slot_only: assert property (!$past(reg_read_in) |-> reg_rdata_out == 16'h0000)
    else $error("read data outside its slot");
  a_temp_then_shunt: assert property (converter_on_out
    && input_select_out == pmcs_pkg::SEL_SHUNT && $past(input_select_out) != pmcs_pkg::SEL_SHUNT
    |-> $past(input_select_out) == pmcs_pkg::SEL_TEMP)
    else $error("shunt period not preceded by temperature");
  a_idle_no_convert: assert property (shutdown_out |-> !converter_on_out)
    else $error("converting while shut down");
  a_mode_write_wakes: assert property (run_wr |-> ##[1:2] !shutdown_out)
    else $error("mode write did not start a sequence");
  a_stop_write_sleeps: assert property (stop_wr |-> ##[1:2] shutdown_out)
    else $error("shutdown write did not stop");
  a_mode_write_clears: assert property (run_wr |-> ##[1:3] !ready_alert_out)
    else $error("ready kept after mode write");
  a_diag_read_clears: assert property (diag_rd && shutdown_out ##1 shutdown_out
    |-> ##[1:2] !ready_alert_out)
    else $error("ready kept after diagnostic read");
  a_switch_restarts: assert property (converter_on_out && $changed(input_select_out)
    |-> ##[0:1] (filter_restart_out || $past(filter_restart_out)))
    else $error("input switched without filter restart");

  c_ready_seen: cover property ($rose(ready_alert_out));
  c_abort_seen: cover property (run_wr && !shutdown_out);
  c_sleep_seen: cover property ($rose(shutdown_out));
endmodule

// File: testbench/power_monitor_conversion_sequencer_test.sv
// Self-checking bench for the power monitor conversion sequencer
`timescale 1ns/1ps

module power_monitor_conversion_sequencer_test;
  logic        clock_in;
  logic        reset_in;
  logic [3:0]  reg_addr_in;
  logic [15:0] reg_wdata_in;
  logic        reg_write_in;
  logic        reg_read_in;
  logic [15:0] reg_rdata_out;
  logic [15:0] adc_data_in;
  logic [1:0]  input_select_out;
  logic        converter_on_out;
  logic        filter_restart_out;
  logic        ready_alert_out;
  logic        shutdown_out;
  logic [15:0] shunt_v;
  logic [15:0] bus_v;
  logic [15:0] temp_v;
  logic [15:0] rd;
  int          mismatches = 0;
  int          comparisons = 0;
  int          cycles = 0;

  pmcs_sequencer #(.TICK_DIV(1)) pmcs_sequencer_inst (.clock_in(clock_in), .reset_in(reset_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
    .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out), .adc_data_in(adc_data_in),
    .input_select_out(input_select_out), .converter_on_out(converter_on_out),
    .filter_restart_out(filter_restart_out), .ready_alert_out(ready_alert_out),
    .shutdown_out(shutdown_out));
  pmcs_adc_model pmcs_adc_model_inst (.clock_in(clock_in), .select_in(input_select_out),
    .convert_in(converter_on_out), .shunt_level_in(shunt_v), .bus_level_in(bus_v),
    .temp_level_in(temp_v), .result_out(adc_data_in));

  initial
  begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end

  // ****************************************************************
  // Register port tasks and checks
  // ****************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge clock_in);
    reg_write_in <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp, input string what);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge clock_in);
    reg_read_in <= 1'b0;
    #1;
    rd = reg_rdata_out;
    chk(rd, exp, what);
  endtask

  // Optional mode write, then bounded wait for the ready alert
  task automatic run(input logic wr, input logic [15:0] cfg, input int lo, input int hi);
    int n;
    n = 0;
    if (wr)
      reg_wr(pmcs_pkg::ADDR_ADC_CONFIG, cfg);
    while (ready_alert_out !== 1'b1 && n <= hi)
    begin
      @(posedge clock_in);
      n++;
    end
    comparisons++;
    if (n < lo || n > hi)
    begin
      mismatches++;
      $display("[FAIL] %0t ready after %0d cycles", $time, n);
    end
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      $display("[FAIL] %0t run hung", $time);
      test_done;
    end
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    reset_in = 1'b1;
    reg_addr_in = 4'h0;
    reg_wdata_in = 16'h0000;
    reg_write_in = 1'b0;
    reg_read_in = 1'b0;
    shunt_v = 16'h0400;
    bus_v = 16'h0200;
    temp_v = 16'h0100;
    repeat (5) @(posedge clock_in);
    reset_in <= 1'b0;
    @(posedge clock_in);
    chk({15'h0000, shutdown_out}, 16'h0001, "idle after reset");
    rd_chk(pmcs_pkg::ADDR_ADC_CONFIG, 16'h7B68, "converter config reset");
    rd_chk(pmcs_pkg::ADDR_CONFIG, 16'h0000, "delay reset");
    rd_chk(4'hF, 16'h0000, "unmapped read");
    $display("test reset done");
    reg_wr(pmcs_pkg::ADDR_DIAG, 16'h0001);
    run(1'b1, 16'h3000, 147, 158);
    repeat (3) @(posedge clock_in);
    chk({15'h0000, shutdown_out}, 16'h0001, "single shot sleeps");
    rd_chk(pmcs_pkg::ADDR_BUS_V, 16'h0200, "bus");
    rd_chk(pmcs_pkg::ADDR_TEMP, 16'h0100, "temperature");
    rd_chk(pmcs_pkg::ADDR_CURRENT, 16'h03FC, "corrected current");
    rd_chk(pmcs_pkg::ADDR_POWER, 16'h0007, "power");
    rd_chk(pmcs_pkg::ADDR_DIAG, 16'h0003, "diag single shot");
    repeat (3) @(posedge clock_in);
    chk({15'h0000, ready_alert_out}, 16'h0000, "ready cleared by read");
    $display("test single shot done");
    bus_v <= 16'h0300;
    run(1'b1, 16'h1200, 81, 92);
    rd_chk(pmcs_pkg::ADDR_BUS_V, 16'h0300, "bus only");
    rd_chk(pmcs_pkg::ADDR_CURRENT, 16'h03FC, "current held");
    rd_chk(pmcs_pkg::ADDR_DIAG, 16'h0003, "diag bus only");
    shunt_v <= 16'h0800;
    run(1'b1, 16'h2088, 231, 242);
    rd_chk(pmcs_pkg::ADDR_CURRENT, 16'h07FC, "current only");
    rd_chk(pmcs_pkg::ADDR_BUS_V, 16'h0300, "bus held");
    rd_chk(pmcs_pkg::ADDR_DIAG, 16'h0003, "diag current only");
    $display("test channel modes done");
    run(1'b1, 16'h3001, 598, 612);
    rd_chk(pmcs_pkg::ADDR_POWER, 16'h0017, "averaged power");
    rd_chk(pmcs_pkg::ADDR_DIAG, 16'h0003, "diag averaged");
    $display("test averaging done");
    run(1'b1, 16'h7000, 147, 158);
    rd_chk(pmcs_pkg::ADDR_DIAG, 16'h0007, "diag continuous");
    run(1'b0, 16'h0000, 140, 158);
    rd_chk(pmcs_pkg::ADDR_CHARGE_LO, 16'h0FF8, "charge two passes");
    rd_chk(pmcs_pkg::ADDR_ENERGY_LO, 16'hE800, "energy low word");
    rd_chk(pmcs_pkg::ADDR_ENERGY_HI, 16'h002F, "energy high word");
    reg_wr(pmcs_pkg::ADDR_ADC_CONFIG, 16'h0000);
    repeat (3) @(posedge clock_in);
    chk({14'h0000, ready_alert_out, shutdown_out}, 16'h0003, "stop keeps ready");
    rd_chk(pmcs_pkg::ADDR_CHARGE_LO, 16'h0000, "charge cleared on stop");
    rd_chk(pmcs_pkg::ADDR_DIAG, 16'h0003, "accumulators invalid");
    $display("test continuous done");
    reg_wr(pmcs_pkg::ADDR_CONFIG, 16'h0040);
    reg_wr(pmcs_pkg::ADDR_ADC_CONFIG, 16'h3000);
    repeat (500) @(posedge clock_in);
    chk({14'h0000, converter_on_out, shutdown_out}, 16'h0000, "waiting in delay");
    run(1'b1, 16'h3000, 2147, 2160);
    $display("test delay done");
    test_done;
  end
endmodule

bind pmcs_sequencer pmcs_sequencer_asserts pmcs_sequencer_asserts_inst (.clock_in(clock_in),
  .reset_in(reset_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
  .adc_data_in(adc_data_in), .input_select_out(input_select_out),
  .converter_on_out(converter_on_out), .filter_restart_out(filter_restart_out),
  .ready_alert_out(ready_alert_out), .shutdown_out(shutdown_out));
